// ==== uaf_defs.svh ====
// Offsets, field positions, reset values and counts of the autoflow host port
`ifndef UAF_DEFS_SVH
`define UAF_DEFS_SVH

// ==========================================================================
// Register offsets on the register-select lines
`define UAF_OFF_DATA     3'h0
`define UAF_OFF_IER      3'h1
`define UAF_OFF_FCR      3'h2
`define UAF_OFF_LCR      3'h3
`define UAF_OFF_MODEM    3'h4
`define UAF_OFF_LSR      3'h5
`define UAF_OFF_MSR      3'h6

// ==========================================================================
// Field positions
`define UAF_MODEM_RTS    1
`define UAF_AUTOFLOW     5
`define UAF_LCR_DLAB     7
`define UAF_IER_MS       3
`define UAF_FCR_EN       0
`define UAF_FCR_RXCLR    1
`define UAF_FCR_TRIG_LO  6
`define UAF_FCR_TRIG_HI  7
`define UAF_MSR_DCTS     0
`define UAF_MSR_DDCD     3
`define UAF_MSR_CTS      4
`define UAF_MSR_DCD      7
`define UAF_LSR_DR       0
`define UAF_LSR_OE       1
`define UAF_LSR_THRE     5

// ==========================================================================
// Reset values and counts
`define UAF_RST_BYTE     8'h00
`define UAF_RST_DIV      16'h0000
`define UAF_RST_IER      4'h0
`define UAF_RXQ_FULL     5'h10
`define UAF_RXQ_LAST     5'h0f
`define UAF_TRIG_14      2'h3

`endif

// ==== uaf_far_end.sv ====
// Far-side model: serializer taking transmit bytes and a receiver feeding characters
module uaf_far_end
    import uaf_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Transmitter side
    input  wire logic       i_tx_start,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_idle,
    // Receiver side
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_first_bit,
    output logic            o_rx_busy
);
    timeunit 1ns;
    timeprecision 1ns;

    int         tx_cnt = 0;
    logic [7:0] tx_last = 8'h00;
    int         left = 0;

    // ==========
    // Serializer: a taken byte keeps the line busy up to its last stop bit
    always @(posedge i_clk)
    begin
        if (i_tx_start)
        begin
            left <= 12;
            tx_last <= i_tx_data;
            tx_cnt <= tx_cnt + 1;
        end
        else if (left > 0)
            left <= left - 1;
    end
    assign o_tx_idle = (left == 0);

    // ==========
    // Receiver: data lines show the inverse of the last word between characters
    initial
    begin
        o_rx_valid = 1'b0;
        o_rx_first_bit = 1'b0;
        o_rx_busy = 1'b0;
        o_rx_data = 8'h5a;
    end

    task automatic rx_begin();
        @(negedge i_clk);
        o_rx_busy = 1'b1;
        o_rx_first_bit = 1'b1;
        @(negedge i_clk);
        o_rx_first_bit = 1'b0;
    endtask

    task automatic rx_end(input logic [7:0] b);
        repeat (6) @(negedge i_clk);
        o_rx_valid = 1'b1;
        o_rx_data = b;
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_busy = 1'b0;
        o_rx_data = ~b;
    endtask
endmodule // uaf_far_end

// ==== uaf_host_port.sv ====
// Host-side port of the serial element: bus decode, autoflow, modem status, rate clock
// ==========================================================================
// What this block does
// (R1) Auto-RTS runs only when FIFO enable, the autoflow bit and the RTS bit of modem control are set; auto-CTS needs FIFO enable and the autoflow bit.
// (R2) With FIFO enable and autoflow set and the RTS bit clear, only CTS gating is on and RTS is not driven by the queue.
// (R3) In auto-CTS mode a CTS release lets the byte in progress finish and holds back the next one.
// (R4) In auto-CTS mode, CTS going low again lets queued transmit data flow once more.
// (R5) Receive trigger thresholds of 1, 4, 8 and 14 bytes are offered and steer auto-RTS.
// (R6) For 1, 4 or 8 RTS drops when the queue reaches the threshold and returns once it is read empty.
// (R7) For 14 RTS drops at the first data bit of the sixteenth character; that character fills the queue.
// (R8) For 14 RTS returns with one free slot and no character arriving, or with more than one free slot.
// (R9) With the queue full under threshold 14, the first receive read brings RTS back.
// (R10) The three register-select lines choose the register of every read or write.
// (R11) Selects pass straight through while the address strobe is low and are held from its rising edge.
// (R12) A 16x rate clock of reference over divisor is driven out for the receiver to use if wanted; with divisor 1 the output stays low.
// (R13) Accesses count only with both high selects high and the low select low.
// (R14) CTS level shows in modem status bit 4 and bit 0 flags a change since the last status read.
// (R15) A CTS change interrupts only with modem interrupts enabled and auto-CTS off.
// (R16) Carrier level shows in bit 7, bit 3 flags its change, and a change interrupts when enabled.
// (R17) The 8-bit data bus is driven only during host reads.
`include "uaf_defs.svh"

module uaf_host_port
    import uaf_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Host bus
    input  wire logic       i_reg_sel_0,
    input  wire logic       i_reg_sel_1,
    input  wire logic       i_reg_sel_2,
    input  wire logic       i_select_high_a,
    input  wire logic       i_select_high_b,
    input  wire logic       i_select_low_n,
    input  wire logic       i_address_strobe_n,
    input  wire logic       i_read_n,
    input  wire logic       i_write_n,
    input  wire logic [7:0] i_host_bus,
    output logic [7:0]      o_host_bus,
    output logic            o_host_bus_oe_n,
    // Receiver side
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_first_bit,
    input  wire logic       i_rx_busy,
    // Transmitter side
    output logic            o_tx_start,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_idle,
    // Modem lines
    input  wire logic       i_cts_n,
    input  wire logic       i_dcd_n,
    output logic            o_rts_n,
    output logic            o_irq,
    output logic            o_tx_rate_clock_out
);

    // ======================================================================
    // Declarations
    uaf_state_t s;
    uaf_state_t n;
    uaf_sel_t   sel_live;
    uaf_sel_t   cur_sel;
    logic       sel_ok;
    logic       dlab;
    logic       take_rd;
    logic       take_wr;
    logic       pop;
    logic       push;
    logic       auto_cts;
    logic       auto_rts;
    logic       set14;
    logic       rel14;
    logic [7:0] rd_mux;
    logic       buf_in_valid;
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic [7:0] buf_out_data;
    logic       tx_load;

    function automatic logic [4:0] trig_level(input logic [1:0] code);
        unique case (code)
            2'h0:    trig_level = 5'h01;
            2'h1:    trig_level = 5'h04;
            2'h2:    trig_level = 5'h08;
            default: trig_level = 5'h0e;
        endcase
    endfunction

    // ======================================================================
    // Transmit data buffer; a refused write shows as a cleared room bit
    uaf_pair_buf uaf_pair_buf_i (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (buf_in_valid),
        .i_in_data   (i_host_bus),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (buf_out_valid),
        .o_out_data  (buf_out_data),
        .i_out_ready (tx_load)
    );

    // ======================================================================
    // Next-state logic
    always_comb
    begin
        n        = s;
        sel_live = '{high_a: i_select_high_a, high_b: i_select_high_b, low_n: i_select_low_n,
                     sel: {i_reg_sel_2, i_reg_sel_1, i_reg_sel_0}};
        cur_sel  = i_address_strobe_n ? s.sel_latch : sel_live;                     // R11
        if (!i_address_strobe_n)
        begin
            n.sel_latch = sel_live;                                                  // R11
        end
        sel_ok   = cur_sel.high_a && cur_sel.high_b && !cur_sel.low_n;               // R13
        dlab     = s.lcr[`UAF_LCR_DLAB];
        take_rd  = (s.hs == HS_IDLE) && sel_ok && !i_read_n;
        take_wr  = (s.hs == HS_IDLE) && sel_ok && i_read_n && !i_write_n;
        auto_cts = s.fifo_en && s.modem_control_reg[`UAF_AUTOFLOW];                  // R2
        auto_rts = auto_cts && s.modem_control_reg[`UAF_MODEM_RTS];                  // R1

        // Host access sequencer: one register action per read or write pulse
        unique case (s.hs)
            HS_IDLE:  n.hs = take_rd ? HS_READ : (take_wr ? HS_WRITE : HS_IDLE);
            HS_READ:  n.hs = i_read_n ? HS_IDLE : HS_READ;
            HS_WRITE: n.hs = i_write_n ? HS_IDLE : HS_WRITE;
            default:  n.hs = HS_IDLE;
        endcase

        // Read data selection
        rd_mux = 8'h00;
        unique case (cur_sel.sel)                                                    // R10
            `UAF_OFF_DATA: rd_mux = dlab ? s.div[7:0] : s.rxq[s.rp];
            `UAF_OFF_IER:  rd_mux = dlab ? s.div[15:8] : {4'h0, s.ier};
            `UAF_OFF_LCR:  rd_mux = s.lcr;
            `UAF_OFF_MODEM: rd_mux = s.modem_control_reg;
            `UAF_OFF_LSR:  rd_mux = {2'h0, buf_in_ready, 3'h0, s.overrun, (s.cnt != 5'h00)};
            `UAF_OFF_MSR:  rd_mux = {~i_dcd_n, 2'h0, ~i_cts_n, s.d_dcd, 2'h0, s.d_cts}; // R14 R16
            default:       rd_mux = 8'h00;
        endcase
        if (take_rd)
        begin
            n.dout = rd_mux;
        end
        n.oe_n = !(sel_ok && !i_read_n);                                             // R17

        // Receive queue
        pop  = take_rd && (cur_sel.sel == `UAF_OFF_DATA) && !dlab && (s.cnt != 5'h00);
        push = i_rx_valid && ((s.cnt != `UAF_RXQ_FULL) || pop);
        if (take_rd && (cur_sel.sel == `UAF_OFF_LSR))
        begin
            n.overrun = 1'b0;
        end
        if (i_rx_valid && !push)
        begin
            n.overrun = 1'b1;
        end
        if (push)
        begin
            n.rxq[s.wp] = i_rx_data;
            n.wp        = s.wp + 4'h1;
        end
        if (pop)
        begin
            n.rp = s.rp + 4'h1;
        end
        n.cnt = s.cnt + {4'h0, push} - {4'h0, pop};

        // Host writes
        buf_in_valid = take_wr && (cur_sel.sel == `UAF_OFF_DATA) && !dlab;
        if (take_wr)
        begin
            unique case (cur_sel.sel)                                                // R10
                `UAF_OFF_DATA: if (dlab) n.div[7:0] = i_host_bus;
                `UAF_OFF_IER:
                begin
                    if (dlab) n.div[15:8] = i_host_bus;
                    else      n.ier = i_host_bus[3:0];
                end
                `UAF_OFF_FCR:
                begin
                    n.fifo_en = i_host_bus[`UAF_FCR_EN];
                    n.trig    = i_host_bus[`UAF_FCR_TRIG_HI:`UAF_FCR_TRIG_LO];       // R5
                    if (i_host_bus[`UAF_FCR_RXCLR])
                    begin
                        n.wp  = 4'h0;
                        n.rp  = 4'h0;
                        n.cnt = 5'h00;
                    end
                end
                `UAF_OFF_LCR:  n.lcr = i_host_bus;
                `UAF_OFF_MODEM: n.modem_control_reg = i_host_bus;
                default:       n.lcr = s.lcr;
            endcase
        end

        // Auto-RTS hold; set wins over release at every threshold
        set14 = (i_rx_first_bit && (s.cnt == `UAF_RXQ_LAST)) ||
                ((s.cnt == `UAF_RXQ_FULL) && !pop);                                  // R7
        rel14 = (s.cnt < `UAF_RXQ_LAST) || ((s.cnt == `UAF_RXQ_LAST) && !i_rx_busy) ||
                ((s.cnt == `UAF_RXQ_FULL) && pop);                                   // R8 R9
        if (!auto_rts)
        begin
            n.rts_hold = 1'b0;
        end
        else if (s.trig == `UAF_TRIG_14)
        begin
            n.rts_hold = set14 ? 1'b1 : (rel14 ? 1'b0 : s.rts_hold);
        end
        else
        begin
            n.rts_hold = (s.cnt >= trig_level(s.trig)) ? 1'b1 :                      // R6
                         ((s.cnt == 5'h00) ? 1'b0 : s.rts_hold);
        end
        n.rts_n = auto_rts ? n.rts_hold : ~s.modem_control_reg[`UAF_MODEM_RTS];      // R1 R2

        // Modem status deltas: a read clears, a change in the same cycle wins
        n.cts_q = i_cts_n;
        n.dcd_q = i_dcd_n;
        if (take_rd && (cur_sel.sel == `UAF_OFF_MSR))
        begin
            n.d_cts = 1'b0;
            n.d_dcd = 1'b0;
        end
        if (i_cts_n != s.cts_q)
        begin
            n.d_cts = 1'b1;                                                          // R14
        end
        if (i_dcd_n != s.dcd_q)
        begin
            n.d_dcd = 1'b1;                                                          // R16
        end
        n.irq = s.ier[`UAF_IER_MS] && ((s.d_cts && !auto_cts) || s.d_dcd);          // R15 R16

        // Rate clock; divisor 1 cannot toggle from a flop at this clock and stays low
        if (s.div == `UAF_RST_DIV)
        begin
            n.brg_cnt = 16'h0000;
        end
        else
        begin
            n.brg_cnt = (s.brg_cnt >= s.div - 16'h0001) ? 16'h0000 : s.brg_cnt + 16'h0001;
        end
        n.brg_out = (n.brg_cnt < {1'b0, s.div[15:1]});                               // R12

        // Transmit start; CTS is only looked at between bytes, so a byte under way completes
        tx_load    = i_tx_idle && !s.tx_start && buf_out_valid && (!auto_cts || !i_cts_n); // R3 R4
        n.tx_start = tx_load;
        if (tx_load)
        begin
            n.tx_data = buf_out_data;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s         <= '0;
            s.hs      <= HS_IDLE;
            s.modem_control_reg <= `UAF_RST_BYTE;
            s.lcr     <= `UAF_RST_BYTE;
            s.ier     <= `UAF_RST_IER;
            s.div     <= `UAF_RST_DIV;
            s.rts_n   <= 1'b1;
            s.cts_q   <= 1'b1;
            s.dcd_q   <= 1'b1;
            s.oe_n    <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign o_host_bus          = s.dout;
    assign o_host_bus_oe_n     = s.oe_n;
    assign o_tx_start          = s.tx_start;
    assign o_tx_data           = s.tx_data;
    assign o_rts_n             = s.rts_n;
    assign o_irq               = s.irq;
    assign o_tx_rate_clock_out = s.brg_out;

    // ======================================================================
    // Checks
    a_rts_cts_only: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
        (s.modem_control_reg[`UAF_AUTOFLOW] && !s.modem_control_reg[`UAF_MODEM_RTS]) |=> o_rts_n)
        else $error("RTS driven active with its control bit clear");

    a_cts_gates_tx: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
        (o_tx_start && $past(s.fifo_en && s.modem_control_reg[`UAF_AUTOFLOW])) |-> $past(!i_cts_n))
        else $error("byte started while CTS was released");

    a_cts_resume: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
        (auto_cts && !i_cts_n && i_tx_idle && buf_out_valid && !s.tx_start) |=> o_tx_start)
        else $error("queued byte not started after CTS returned");

    a_trig_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
        (auto_rts && s.trig != `UAF_TRIG_14 && s.cnt >= trig_level(s.trig)) |=> o_rts_n)
        else $error("RTS still active at the trigger level");

    a_empty_go: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
        (auto_rts && s.trig != `UAF_TRIG_14 && s.cnt == 5'h00) |=> !o_rts_n)
        else $error("RTS not back with the queue empty");

    a_stop_sixteenth: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
        (auto_rts && s.trig == `UAF_TRIG_14 && i_rx_first_bit && s.cnt == 5'h0f) |=> o_rts_n)
        else $error("RTS not dropped at the sixteenth character");

    a_room_go: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
        (auto_rts && s.trig == `UAF_TRIG_14 && s.cnt < 5'h0f) |=> !o_rts_n)
        else $error("RTS held with more than one free slot");

    a_full_read_go: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        (auto_rts && s.trig == `UAF_TRIG_14 && s.cnt == 5'h10 && pop) |=> !o_rts_n)
        else $error("RTS not back after a read of the full queue");

    a_strobe_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
        (i_address_strobe_n && $past(i_address_strobe_n)) |-> (s.sel_latch == $past(s.sel_latch)))
        else $error("latched selects moved while the strobe was high");

    a_bus_float: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13 R17
        !(sel_ok && !i_read_n) |=> o_host_bus_oe_n)
        else $error("data bus driven outside a selected read");

    a_cts_delta: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
        (i_cts_n != s.cts_q) |=> s.d_cts)
        else $error("CTS change not flagged");

    a_no_cts_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
        (auto_cts && !s.d_dcd) |=> !o_irq)
        else $error("CTS change interrupted in auto-CTS mode");

    a_dcd_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
        (s.d_dcd && s.ier[`UAF_IER_MS]) |=> o_irq)
        else $error("carrier change did not interrupt");

endmodule // uaf_host_port

// ==== uaf_host_port_bench.sv ====
// Self-checking bench of the autoflow host port
module uaf_host_port_bench;
    import uaf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rst_n, as_n, rd_n, wr_n, ha, hb, ln, cts_n, dcd_n;
    logic [2:0] sel;
    logic [7:0] hbus, o_host_bus, b, b2, q, d, h;
    logic       oe_n, tx_start, tx_idle, rx_valid, rx_first, rx_busy, rts_n, irq, rate;
    logic [7:0] tx_data, rx_data;
    logic [7:0] exq[$];
    int         fails = 0;
    int         check_count = 0;

    always #5 clk = ~clk;

    uaf_host_port uaf_host_port_i (.i_clk(clk), .i_rst_n(rst_n), .i_reg_sel_0(sel[0]), .i_reg_sel_1(sel[1]),
        .i_reg_sel_2(sel[2]), .i_select_high_a(ha), .i_select_high_b(hb), .i_select_low_n(ln),
        .i_address_strobe_n(as_n), .i_read_n(rd_n), .i_write_n(wr_n), .i_host_bus(hbus),
        .o_host_bus(o_host_bus), .o_host_bus_oe_n(oe_n), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .i_rx_first_bit(rx_first), .i_rx_busy(rx_busy), .o_tx_start(tx_start), .o_tx_data(tx_data),
        .i_tx_idle(tx_idle), .i_cts_n(cts_n), .i_dcd_n(dcd_n), .o_rts_n(rts_n), .o_irq(irq),
        .o_tx_rate_clock_out(rate));

    uaf_far_end uaf_far_end_i (.i_clk(clk), .i_tx_start(tx_start), .i_tx_data(tx_data), .o_tx_idle(tx_idle),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_first_bit(rx_first), .o_rx_busy(rx_busy));

    // ==========
    // Expectations and checks
    function automatic int trig_n(input int c);
        return (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========
    // Host cycles; with lat set the strobe latch supplies the selects
    task automatic acc(input logic wr, input logic lat, input logic [2:0] a, input logic [7:0] v,
                       output logic [7:0] r);
        @(negedge clk);
        if (!lat)
        begin
            sel = a;
            as_n = 1'b0;
        end
        rd_n = wr;
        wr_n = !wr;
        hbus = v;
        repeat (2) @(negedge clk);
        r = o_host_bus;
        if (!wr)
            chk("bus enable", 8'h00, {7'h0, oe_n});
        rd_n = 1'b1;
        wr_n = 1'b1;
        as_n = 1'b1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        logic [7:0] r;
        acc(1'b1, 1'b0, a, v, r);
    endtask

    task automatic drain();
        logic [7:0] r;
        while (exq.size() > 0)
        begin
            acc(1'b0, 1'b0, 3'h0, 8'h00, r);
            chk("rx data", exq.pop_front(), r);
        end
    endtask

    task automatic rx_chars(input int n);
        for (int i = 0; i < n; i++)
        begin
            b = 8'($urandom);
            exq.push_back(b);
            uaf_far_end_i.rx_begin();
            uaf_far_end_i.rx_end(b);
        end
    endtask

    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (uaf_far_end_i.tx_cnt != n && k < 60)
        begin
            @(negedge clk);
            k++;
        end
        if (uaf_far_end_i.tx_cnt != n)
        begin
            fails++;
            conclude();
        end
    endtask

    // ==========
    // Main sequence
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {sel, ha, hb, ln, as_n, rd_n, wr_n, hbus} = {3'h0, 3'b110, 3'b111, 8'h00};
        {cts_n, dcd_n} = 2'b11;
        void'($urandom(32'hbbda));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk("rts", 8'h01, {7'h0, rts_n});
        wr(3'h4, 8'h22);
        ln = 1'b1;
        wr(3'h4, 8'h00);
        ln = 1'b0;
        acc(1'b0, 1'b0, 3'h5, 8'h00, q);
        chk("line status", 8'h20, q);
        acc(1'b0, 1'b0, 3'h4, 8'h00, q);
        chk("modem control", 8'h22, q);
        @(negedge clk);
        as_n = 1'b0;
        @(negedge clk);
        as_n = 1'b1;
        sel = 3'h3;
        acc(1'b0, 1'b1, 3'h0, 8'h00, q);
        chk("latched read", 8'h22, q);
        for (int c = 0; c < 4; c++)
        begin
            wr(3'h2, {2'(c), 6'h03});
            // Threshold 14 is tested on the sixteenth character, so fifteen go first
            rx_chars((c == 3) ? 15 : trig_n(c) - 1);
            uaf_far_end_i.rx_begin();
            chk("rts", {7'h0, c == 3}, {7'h0, rts_n});
            @(negedge clk);
            chk("rts", {7'h0, c == 3}, {7'h0, rts_n});
            b = 8'($urandom);
            exq.push_back(b);
            uaf_far_end_i.rx_end(b);
            if (c == 3)
            begin
                acc(1'b0, 1'b0, 3'h0, 8'h00, q);
                chk("rx data", exq.pop_front(), q);
                @(negedge clk);
                chk("rts", 8'h00, {7'h0, rts_n});
            end
            else
            begin
                repeat (2) @(negedge clk);
                chk("rts", 8'h01, {7'h0, rts_n});
            end
            drain();
            @(negedge clk);
            chk("rts", 8'h00, {7'h0, rts_n});
        end
        wr(3'h4, 8'h20);
        @(negedge clk);
        chk("rts", 8'h01, {7'h0, rts_n});
        cts_n = 1'b0;
        b = 8'($urandom);
        b2 = 8'($urandom);
        wr(3'h0, b);
        wr(3'h0, b2);
        wait_tx(1);
        cts_n = 1'b1;
        chk("tx data", b, uaf_far_end_i.tx_last);
        repeat (40) @(negedge clk);
        chk("tx count", 8'h01, uaf_far_end_i.tx_cnt[7:0]);
        cts_n = 1'b0;
        wait_tx(2);
        chk("tx data", b2, uaf_far_end_i.tx_last);
        acc(1'b0, 1'b0, 3'h6, 8'h00, q);
        wr(3'h1, 8'h08);
        cts_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("irq", 8'h00, {7'h0, irq});
        dcd_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        acc(1'b0, 1'b0, 3'h6, 8'h00, q);
        chk("msr", 8'h89, q & 8'h99);
        repeat (3) @(negedge clk);
        chk("irq", 8'h00, {7'h0, irq});
        wr(3'h4, 8'h00);
        cts_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        acc(1'b0, 1'b0, 3'h6, 8'h00, q);
        chk("msr", 8'h91, q & 8'h99);
        d = 8'(2 * ($urandom % 4 + 1));
        wr(3'h3, 8'h80);
        wr(3'h0, d);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h00);
        repeat (16) @(negedge clk);
        h = 8'h00;
        repeat (8 * d)
        begin
            @(negedge clk);
            h = h + {7'h0, rate};
        end
        chk("rate clock", 8'(4 * d), h);
        conclude();
    end
endmodule // uaf_host_port_bench

// ==== uaf_pair_buf.sv ====
// Two-entry valid/ready buffer between host writes and the transmitter
`include "uaf_defs.svh"

module uaf_pair_buf
    import uaf_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Filling side
    input  wire logic       i_in_valid,
    input  wire logic [7:0] i_in_data,
    output logic            o_in_ready,
    // Draining side
    output logic            o_out_valid,
    output logic [7:0]      o_out_data,
    input  wire logic       i_out_ready
);

    uaf_buf_st_t s_r;
    uaf_buf_st_t s_nxt;
    logic        push;
    logic        pop;

    assign o_in_ready  = (s_r.cnt != 2'h2);
    assign o_out_valid = (s_r.cnt != 2'h0);
    assign o_out_data  = s_r.mem[s_r.rp];

    always_comb
    begin
        s_nxt = s_r;
        push  = i_in_valid && o_in_ready;
        pop   = i_out_ready && o_out_valid;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = i_in_data;
            s_nxt.wp          = ~s_r.wp;
        end
        if (pop)
        begin
            s_nxt.rp = ~s_r.rp;
        end
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    a_buf_no_over: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (s_r.cnt == 2'h2 && !pop) |=> (s_r.cnt == 2'h2))
        else $error("buffer count left full without a pop");

endmodule // uaf_pair_buf

// ==== uaf_pkg.sv ====
// Types shared by the autoflow host port and its transmit buffer
package uaf_pkg;

    // ======================================================================
    // Host select group, as seen on the pins or as held by the strobe latch
    typedef struct packed {
        logic       high_a;
        logic       high_b;
        logic       low_n;
        logic [2:0] sel;
    } uaf_sel_t;

    // ======================================================================
    // Host access sequencer
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b001,
        HS_READ  = 3'b010,
        HS_WRITE = 3'b100
    } uaf_hs_t;

    // ======================================================================
    // State of the two-entry buffer
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wp;
        logic            rp;
        logic [1:0]      cnt;
    } uaf_buf_st_t;

    // ======================================================================
    // State of the host port
    typedef struct packed {
        uaf_hs_t          hs;
        uaf_sel_t         sel_latch;
        logic [7:0]       modem_control_reg;
        logic [3:0]       ier;
        logic [7:0]       lcr;
        logic [1:0]       trig;
        logic             fifo_en;
        logic [15:0]      div;
        logic [15:0]      brg_cnt;
        logic             brg_out;
        logic [15:0][7:0] rxq;
        logic [3:0]       wp;
        logic [3:0]       rp;
        logic [4:0]       cnt;
        logic             overrun;
        logic             rts_hold;
        logic             rts_n;
        logic             cts_q;
        logic             dcd_q;
        logic             d_cts;
        logic             d_dcd;
        logic             irq;
        logic [7:0]       dout;
        logic             oe_n;
        logic             tx_start;
        logic [7:0]       tx_data;
    } uaf_state_t;

endpackage
